// ---- bench/nvs_master.sv ----
// two-wire bus master model driving scl and pulling sda low
// assumes sda is resolved outside from every party's pull-down enable
`timescale 1ns/10ps
module nvs_master
(
  // system clock
  input  wire logic clk,
  // bus side
  output logic      scl,
  output logic      m_oe,
  input  wire logic sda
);
  // ************************************************************
  // pacing: half scl period in clk cycles, 10 gives 1 MHz
  // ************************************************************
  int hp = 10;

  initial
  begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ************************************************************
  // bus conditions; scl stands high between frames
  // ************************************************************
  task automatic start();
    m_oe = 1'b0;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp / 2);
    m_oe = 1'b1;
    wt(hp / 2);
    scl = 1'b0;
    wt(hp / 2);
  endtask

  task automatic stop();
    m_oe = 1'b1;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp / 2);
    m_oe = 1'b0;
    wt(hp);
  endtask

  // sda only moves while scl is low
  task automatic bit_xfer(input logic b, output logic r);
    m_oe = ~b;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp / 2);
    r = sda;
    wt(hp / 2);
    scl = 1'b0;
    wt(hp / 2);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask

  // ack high asks for more, low ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask
endmodule

// ---- bench/nvs_slave_bench.sv ----
// self-checking bench for the serial byte-memory slave
// assumes nvs_pkg and the design files are compiled first
`timescale 1ns/10ps
module nvs_slave_bench;
  logic       clk;
  logic       arst_n;
  logic       scl;
  logic       m_oe;
  logic       sda;
  logic       sda_o;
  logic       sda_oe;
  logic       wp;
  logic [2:0] device_select_pins;
  int         mismatches;
  int         num_checks;

  // ************************************************************
  // wire-and with pull-up
  // ************************************************************
  assign sda = ~(sda_oe | m_oe);

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    wp = 1'b0;
    device_select_pins = 3'h0;
  end
  always #25 clk = ~clk;

  nvs_slave #(.ID_CODE(nvs_pkg::ID_CODE_DEF)) DUT
  (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .device_select_pins(device_select_pins), .wp(wp)
  );

  nvs_master u_mst (.clk(clk), .scl(scl), .m_oe(m_oe), .sda(sda));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] dev(input logic [2:0] ds, input logic rw);
    return {nvs_pkg::ID_CODE_DEF, ds, rw};
  endfunction

  task automatic set_ptr(input logic [15:0] a);
    logic ak;
    u_mst.start();
    u_mst.wr_byte(dev(device_select_pins, 1'b0), ak);
    chk(ak === 1'b1, "device address not acked");
    u_mst.wr_byte(a[15:8], ak);
    chk(ak === 1'b1, "high address not acked");
    u_mst.wr_byte(a[7:0], ak);
    chk(ak === 1'b1, "low address not acked");
  endtask

  task automatic wr_seq(input logic [15:0] a, input logic [7:0] s, input int n);
    logic ak;
    set_ptr(a);
    for (int k = 0; k < n; k++)
    begin
      u_mst.wr_byte(s + 8'(k * 17), ak);
      chk(ak === 1'b1, "data byte not acked");
    end
    u_mst.stop();
  endtask

  task automatic rd_seq(input logic [15:0] a, input logic [7:0] s, input int n);
    logic       ak;
    logic [7:0] d;
    set_ptr(a);
    u_mst.start();
    u_mst.wr_byte(dev(device_select_pins, 1'b1), ak);
    chk(ak === 1'b1, "read address not acked");
    for (int k = 0; k < n; k++)
    begin
      u_mst.rd_byte(k != n - 1, d);
      chk(d === s + 8'(k * 17), "read data wrong");
    end
    u_mst.stop();
  endtask

  task automatic cur_rd(input logic [7:0] e);
    logic       ak;
    logic [7:0] d;
    u_mst.start();
    u_mst.wr_byte(dev(device_select_pins, 1'b1), ak);
    chk(ak === 1'b1, "read address not acked");
    u_mst.rd_byte(1'b0, d);
    chk(d === e, "current address read wrong");
    u_mst.stop();
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_basic();
    wr_seq(16'he123, 8'h3c, 4);
    rd_seq(16'he123, 8'h3c, 4);
    rd_seq(16'h0123, 8'h3c, 4);
    $display("test basic done");
  endtask

  task automatic t_wrap();
    wr_seq(16'h1fff, 8'ha0, 2);
    rd_seq(16'h1fff, 8'ha0, 2);
    rd_seq(16'h0000, 8'hb1, 1);
    $display("test wrap done");
  endtask

  // a matching address after a mismatch must still be ignored
  task automatic t_dsel();
    logic ak;
    for (int i = 0; i < 8; i++)
    begin
      device_select_pins = 3'(i);
      u_mst.start();
      u_mst.wr_byte(dev(3'(i), 1'b0), ak);
      chk(ak === 1'b1, "matching select not acked");
      u_mst.stop();
      u_mst.start();
      u_mst.wr_byte(dev(3'(i) ^ 3'h1, 1'b0), ak);
      chk(ak === 1'b0, "foreign select acked");
      u_mst.wr_byte(dev(3'(i), 1'b0), ak);
      chk(ak === 1'b0, "sda pulled after mismatch");
      u_mst.stop();
    end
    device_select_pins = 3'h0;
    $display("test dsel done");
  endtask

  task automatic t_wp();
    wr_seq(16'h0200, 8'h10, 4);
    wp = 1'b1;
    wr_seq(16'h0200, 8'hc5, 2);
    cur_rd(8'h32);
    wp = 1'b0;
    rd_seq(16'h0200, 8'h10, 4);
    $display("test wp done");
  endtask

  // 100 kHz and 400 kHz pacing
  task automatic t_speed();
    int h[2] = '{100, 25};
    for (int j = 0; j < 2; j++)
    begin
      u_mst.hp = h[j];
      wr_seq(16'h0400 + 16'(j), 8'h77, 1);
      rd_seq(16'h0400 + 16'(j), 8'h77, 1);
    end
    u_mst.hp = 10;
    $display("test speed done");
  endtask

  // address latch clears on reset, the array keeps its bytes
  task automatic t_reset();
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    cur_rd(8'hb1);
    $display("test reset done");
  endtask

  // ************************************************************
  // pin watchers
  // ************************************************************
  always @(sda_oe)
    if (arst_n === 1'b1)
      chk(scl === 1'b0, "sda moved while scl high");

  always @(posedge scl)
    if (sda_oe === 1'b1)
      chk(sda_o === 1'b0, "sda driven high");

  // bounded well above the roughly 40000 cycles the tests need
  initial
  begin
    repeat (80000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_basic();
    t_wrap();
    t_dsel();
    t_wp();
    t_speed();
    t_reset();
    end_sim();
  end
endmodule

// ---- rtl/nvs_pkg.sv ----
// package for the serial byte-memory slave: sizes, state codes, timing
// assumes a single system clock of 20 MHz oversampling the two-wire bus
package nvs_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MEM_DEPTH  = 8192;
  localparam logic [12:0] ADDR_LAST  = 13'h1fff;
  localparam logic [12:0] ADDR_FIRST = 13'h0000;
  localparam logic [12:0] ADDR_RST   = 13'h0000;

  // ************************************************************
  // slave address byte layout
  // ************************************************************
  localparam int unsigned ID_MSB   = 7;
  localparam int unsigned ID_LSB   = 4;
  localparam int unsigned DSEL_MSB = 3;
  localparam int unsigned DSEL_LSB = 1;
  localparam int unsigned RW_POS   = 0;
  localparam int unsigned DSEL_W   = 3;
  // arbitrary neutral value, not any maker's code
  localparam logic [3:0]  ID_CODE_DEF = 4'h5;

  // ************************************************************
  // bit counting and reset values
  // ************************************************************
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned SCL_MAX_KHZ       = 1000;
  localparam int unsigned SCL_MIN_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  // samples of one fastest scl period, rounded down
  localparam int unsigned SCL_SAMPLES       = SCL_MIN_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_DEVADR = 3'b001,
    ST_ADRHI  = 3'b010,
    ST_ADRLO  = 3'b011,
    ST_WDATA  = 3'b100,
    ST_RDATA  = 3'b101,
    ST_IGNORE = 3'b110
  } nvs_state_type;

endpackage

// ---- rtl/nvs_slave.sv ----
// two-wire serial slave in front of an 8K x 8 byte array
// assumes clk far faster than scl; scl also clocks the sda output stage
//
// Operation
// - array of 8192 locations, eight bits each, chosen by internal address
// - each received data byte written to the array the moment it completes
// - no busy phase; a new transaction is accepted right after a write
// - answer only when device select pins equal the address bits
// - unconnected device select pins count as zero; no internal pull-down here, the pins must be tied low at the pad
// - sample bits on scl rising edge, change sda on falling edge
// - write protect high blocks all writes; low allows all writes
// - unconnected write protect counts as low, writes enabled; no internal pull-down here, wp must be tied low at the pad
// - works with scl up to 1 MHz, also 100 and 400 kHz
// - sda only pulled low or released, never driven high
// - two address bytes; 13 bits kept, upper 3 bits ignored
// - address advances per data byte and wraps from last to zero
// - read continues on master ack, ends on master nack
// - every address and data byte travels most significant bit first
`timescale 1ns/10ps
module nvs_slave
#(
  parameter logic [3:0] ID_CODE = nvs_pkg::ID_CODE_DEF
)
(
  // system clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // two-wire bus, scl is the link clock
  input  wire logic                       scl,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  // straps
  input  wire logic [nvs_pkg::DSEL_W-1:0] device_select_pins,
  input  wire logic                       wp
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [nvs_pkg::DSEL_W+2:0] pins_s;
  logic                       scl_s;
  logic                       sda_s;
  logic [nvs_pkg::DSEL_W-1:0] dsel_s;
  logic                       wp_s;

  // 20 samples per fastest scl period leave room for the sync delay
  nvs_sync #(.WIDTH(nvs_pkg::DSEL_W + 3)) u_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({scl, sda_i, wp, device_select_pins}),
    .q      (pins_s)
  );

  // floating straps must be tied low at the pad; reset value is low too
  assign scl_s  = pins_s[nvs_pkg::DSEL_W+2];
  assign sda_s  = pins_s[nvs_pkg::DSEL_W+1];
  assign wp_s   = pins_s[nvs_pkg::DSEL_W];
  assign dsel_s = pins_s[nvs_pkg::DSEL_W-1:0];

  // ************************************************************
  // bus event detection
  // ************************************************************
  logic scl_prev_reg;
  logic scl_prev_next;
  logic sda_prev_reg;
  logic sda_prev_next;
  logic scl_rise;
  logic bus_start;
  logic bus_stop;

  always_comb
  begin
    scl_prev_next = scl_s;
    sda_prev_next = sda_s;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ************************************************************
  // protocol engine
  // ************************************************************
  logic [nvs_pkg::DATA_W-1:0] mem [nvs_pkg::MEM_DEPTH];

  nvs_pkg::nvs_state_type     state_reg;
  nvs_pkg::nvs_state_type     state_next;
  logic [3:0]                 bit_reg;
  logic [3:0]                 bit_next;
  logic [7:0]                 shift_reg;
  logic [7:0]                 shift_next;
  logic [nvs_pkg::ADDR_W-1:0] addr_reg;
  logic [nvs_pkg::ADDR_W-1:0] addr_next;
  logic [7:0]                 tx_reg;
  logic [7:0]                 tx_next;
  logic                       drive_reg;
  logic                       drive_next;
  logic [7:0]                 rx_byte;
  logic                       byte_done;
  logic                       ack_slot;
  logic                       addr_match;
  logic                       wr_en;
  logic                       rd_load;
  logic                       pend_reg;
  logic                       pend_next;

  // full byte as it stands after the eighth bit, msb first
  assign rx_byte    = {shift_reg[6:0], sda_s};
  assign byte_done  = scl_rise & (bit_reg == nvs_pkg::BIT_LAST);
  assign ack_slot   = scl_rise & (bit_reg == nvs_pkg::BIT_ACK);
  assign addr_match = (rx_byte[nvs_pkg::ID_MSB:nvs_pkg::ID_LSB] == ID_CODE)
    && (rx_byte[nvs_pkg::DSEL_MSB:nvs_pkg::DSEL_LSB] == dsel_s);
  // write lands on the very edge that completes the byte
  assign wr_en      = byte_done && (state_reg == nvs_pkg::ST_WDATA) && !wp_s;
  // own address ack holds sda low here, so the first fetch is marked by pend_reg
  assign rd_load    = ack_slot && (state_reg == nvs_pkg::ST_RDATA) && (!sda_s || pend_reg);

  always_comb
  begin
    state_next = state_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    addr_next  = addr_reg;
    tx_next    = tx_reg;
    drive_next = drive_reg;
    if (bus_start)
    begin
      // a start aborts anything, even right after a write
      state_next = nvs_pkg::ST_DEVADR;
      bit_next   = nvs_pkg::BIT_FIRST;
      drive_next = 1'b0;
    end
    else if (bus_stop)
    begin
      state_next = nvs_pkg::ST_IDLE;
      bit_next   = nvs_pkg::BIT_FIRST;
      drive_next = 1'b0;
    end
    else if (scl_rise && (state_reg != nvs_pkg::ST_IDLE)
      && (state_reg != nvs_pkg::ST_IGNORE))
    begin
      if (bit_reg == nvs_pkg::BIT_ACK)
      begin
        bit_next = nvs_pkg::BIT_FIRST;
        if (state_reg == nvs_pkg::ST_RDATA)
        begin
          if (rd_load)
          begin
            // master ack or first byte: msb driven after the coming fall
            tx_next    = mem[addr_reg];
            addr_next  = addr_reg + 13'h0001;
            drive_next = ~mem[addr_reg][7];
          end
          else
          begin
            state_next = nvs_pkg::ST_IGNORE;
            drive_next = 1'b0;
          end
        end
        else
        begin
          drive_next = 1'b0;
        end
      end
      else if (bit_reg == nvs_pkg::BIT_LAST)
      begin
        bit_next   = nvs_pkg::BIT_ACK;
        shift_next = rx_byte;
        drive_next = 1'b1;
        unique case (state_reg)
          nvs_pkg::ST_DEVADR:
          begin
            if (!addr_match)
            begin
              state_next = nvs_pkg::ST_IGNORE;
              drive_next = 1'b0;
            end
            else if (rx_byte[nvs_pkg::RW_POS])
            begin
              state_next = nvs_pkg::ST_RDATA;
            end
            else
            begin
              state_next = nvs_pkg::ST_ADRHI;
            end
          end
          nvs_pkg::ST_ADRHI:
          begin
            // top three bits of the high byte are dropped
            addr_next[12:8] = rx_byte[4:0];
            state_next      = nvs_pkg::ST_ADRLO;
          end
          nvs_pkg::ST_ADRLO:
          begin
            addr_next[7:0] = rx_byte;
            state_next     = nvs_pkg::ST_WDATA;
          end
          nvs_pkg::ST_WDATA:
          begin
            // protected bytes still acked and counted
            addr_next = addr_reg + 13'h0001;
          end
          nvs_pkg::ST_RDATA:
          begin
            drive_next = 1'b0; // release for the master's answer
          end
          default:
          begin
            drive_next = 1'b0;
          end
        endcase
      end
      else
      begin
        bit_next   = bit_reg + 4'h1;
        shift_next = rx_byte;
        if (state_reg == nvs_pkg::ST_RDATA)
        begin
          // preset the next read bit, shown on the following fall
          drive_next = ~tx_reg[3'(4'h6 - bit_reg)];
        end
        else
        begin
          drive_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= nvs_pkg::ST_IDLE;
      bit_reg   <= nvs_pkg::BIT_FIRST;
      shift_reg <= nvs_pkg::BYTE_RST;
      addr_reg  <= nvs_pkg::ADDR_RST;
      tx_reg    <= nvs_pkg::BYTE_RST;
      drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      tx_reg    <= tx_next;
      drive_reg <= drive_next;
    end
  end

  // first read byte is fetched on the ack of the slave address
  logic first_rd;
  assign first_rd = byte_done && (state_reg == nvs_pkg::ST_DEVADR)
    && addr_match && rx_byte[nvs_pkg::RW_POS];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr_reg] <= rx_byte;
    end
  end

  // ************************************************************
  // first read byte preload
  // ************************************************************

  always_comb
  begin
    pend_next = pend_reg;
    if (bus_start || bus_stop)
    begin
      pend_next = 1'b0;
    end
    else if (first_rd)
    begin
      pend_next = 1'b1;
    end
    else if (ack_slot)
    begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_reg <= 1'b0;
    end
    else
    begin
      pend_reg <= pend_next;
    end
  end

  // ************************************************************
  // sda output stage, link clock domain
  // ************************************************************
  // drive_reg settles within a few clk after the rise and holds through
  // the fall, so the single capture flop never sees it move
  logic oe_reg;
  logic oe_next;

  always_comb
  begin
    oe_next = drive_reg;
  end

  always_ff @(negedge scl or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;

  // ************************************************************
  // checks
  // ************************************************************
  a_sda_never_high: assert property (@(posedge clk) disable iff (!arst_n)
    sda_oe |-> (sda_o == 1'b0)) else $error("sda driven high");

  a_start_rearms: assert property (@(posedge clk) disable iff (!arst_n)
    bus_start |=> (state_reg == nvs_pkg::ST_DEVADR) && (bit_reg == 4'h0))
    else $error("start did not rearm engine");

  a_mismatch_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == nvs_pkg::ST_IGNORE) |-> !drive_reg)
    else $error("sda pulled while ignoring");

  a_mismatch_ignore: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done && (state_reg == nvs_pkg::ST_DEVADR) && !bus_start && !bus_stop
    && !addr_match |=> (state_reg == nvs_pkg::ST_IGNORE))
    else $error("foreign address not ignored");

  a_wp_blocks_write: assert property (@(posedge clk) disable iff (!arst_n)
    wp_s |-> !wr_en) else $error("write while protected");

  a_write_at_once: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done && (state_reg == nvs_pkg::ST_WDATA) && !wp_s |-> wr_en)
    else $error("completed byte not written");

  a_addr_wraps: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && (addr_reg == nvs_pkg::ADDR_LAST) && !bus_start && !bus_stop
    |=> (addr_reg == nvs_pkg::ADDR_FIRST)) else $error("address did not wrap");

  a_prot_advance: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done && (state_reg == nvs_pkg::ST_WDATA) && wp_s && !bus_start && !bus_stop
    |=> (addr_reg == $past(addr_reg) + 13'h0001) && drive_reg)
    else $error("protected byte not acked or counted");

  a_nack_ends_read: assert property (@(posedge clk) disable iff (!arst_n)
    ack_slot && (state_reg == nvs_pkg::ST_RDATA) && sda_s && !bus_start && !bus_stop && !pend_reg
    |=> (state_reg == nvs_pkg::ST_IGNORE) ##1 !drive_reg)
    else $error("nack did not end read");

  a_ack_after_adr: assert property (@(posedge clk) disable iff (!arst_n)
    byte_done && (state_reg == nvs_pkg::ST_ADRLO) && !bus_start && !bus_stop
    |=> (addr_reg[7:0] == $past(rx_byte)) && drive_reg)
    else $error("low address byte not latched");

endmodule

// ---- rtl/nvs_sync.sv ----
// two-flop level synchroniser, WIDTH bits wide
// assumes each bit changes slowly relative to clk
`timescale 1ns/10ps
module nvs_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb
  begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;

endmodule
